/* File: hw/sp1_port.v */
// second serial port: wishbone register file, address match, interrupt
// assumes a 32-bit classic wishbone master; the line is synchronised here by two flops
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sp1_regs.vh"
module sp1_port #(
  parameter [15:0] T1_PERIOD = `SP1_T1_PERIOD
) (
  // system
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // serial line
  input  wire        rxd_i,
  output reg         rxd_o,
  output reg         rxd_oe_n_o,
  output reg         txd_o,
  // interrupt request
  output reg         irq_o
);
  reg        rx_s1_q;
  reg        rx_s2_q;
  reg [7:0]  mask_q;
  reg [7:0]  given_q;
  reg [7:0]  rxbuf_q;
  reg        mode_hi_q;
  reg        mode_lo_q;
  reg        mp_q;
  reg        ren_q;
  reg        tb8_q;
  reg        rb8_q;
  reg        ti_q;
  reg        ri_q;
  reg        fe_q;
  reg        fev_q;
  reg        dbl_q;
  reg        ien_q;
  reg        tx_go_q;
  reg        rx_go_q;
  reg [7:0]  txbyte_q;
  wire       sh_txd;
  wire       sh_sclk;
  wire       sh_oe_n;
  wire       sh_tdone;
  wire       sh_rdone;
  wire [7:0] sh_byte;
  wire       sh_nine;
  wire       sh_stop;
  wire [1:0] mode = {mode_hi_q, mode_lo_q};

  // masked address match; an all-zero mask matches anything
  function addr_hit;
    input [7:0] data;
    input [7:0] given;
    input [7:0] mask;
    begin
      addr_hit = ((data ^ given) & mask) == 8'h00;
    end
  endfunction

  reg [15:0] period;
  always @* begin
    case (mode)
      2'd0:    period = mp_q ? `SP1_MODE0_FAST : `SP1_MODE0_SLOW;
      2'd2:    period = dbl_q ? `SP1_MODE2_FAST : `SP1_MODE2_SLOW;
      default: period = T1_PERIOD;
    endcase
  end

  // accept rule for a finished frame
  reg accept;
  always @* begin
    accept = 1'b1;
    if (mode == 2'd1 && mp_q)
      accept = sh_stop;
    else if (mode[1] && mp_q)
      accept = sh_nine && addr_hit(sh_byte, given_q, mask_q);
  end

  // register read view of control
  wire [7:0] ctrl_view = {fev_q ? fe_q : mode_hi_q, mode_lo_q, mp_q, ren_q,
                          tb8_q, rb8_q, ti_q, ri_q};

  wire wb_req = cyc_i && stb_i && !ack_o;
  wire wr_lo  = wb_req && we_i && sel_i[0];
  wire rd     = wb_req && !we_i;

  sp1_shifter u_shift (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .mode_i       (mode),
    .period_i     (period),
    .tx_nine_i    (tb8_q),
    .tx_go_i      (tx_go_q),
    .tx_byte_i    (txbyte_q),
    .rx_en_i      (ren_q),
    .rx_go_i      (rx_go_q),
    .rx_i         (rx_s2_q),
    .txd_o        (sh_txd),
    .sclk_o       (sh_sclk),
    .rxd_oe_n_o   (sh_oe_n),
    .tx_done_o    (sh_tdone),
    .rx_done_o    (sh_rdone),
    .rx_byte_o    (sh_byte),
    .rx_nine_o    (sh_nine),
    .rx_stop_ok_o (sh_stop)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_q <= 1'b1; rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd_i;
      rx_s2_q <= rx_s1_q;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0; dat_o <= 32'h0000_0000;
      mask_q <= `SP1_RESET_BYTE; given_q <= `SP1_RESET_BYTE; rxbuf_q <= `SP1_RESET_BYTE;
      txbyte_q <= `SP1_RESET_BYTE;
      mode_hi_q <= 1'b0; mode_lo_q <= 1'b0; mp_q <= 1'b0; ren_q <= 1'b0;
      tb8_q <= 1'b0; rb8_q <= 1'b0; ti_q <= 1'b0; ri_q <= 1'b0; fe_q <= 1'b0;
      fev_q <= 1'b0; dbl_q <= 1'b0; ien_q <= 1'b0;
      tx_go_q <= 1'b0; rx_go_q <= 1'b0;
      irq_o <= 1'b0; txd_o <= 1'b1; rxd_o <= 1'b1; rxd_oe_n_o <= 1'b1;
    end else begin
      ack_o   <= wb_req;
      tx_go_q <= 1'b0;
      rx_go_q <= 1'b0;
      dat_o   <= 32'h0000_0000;
      if (rd) begin
        case (adr_i)
          `SP1_ADDR_MASK:  dat_o[7:0] <= mask_q;
          `SP1_GIVEN_ADDR: dat_o[7:0] <= given_q;
          `SP1_CTRL:       dat_o[7:0] <= ctrl_view;
          `SP1_DATA:       dat_o[7:0] <= rxbuf_q;
          `SP1_AUX:        dat_o[7:0] <= {5'h00, ien_q, dbl_q, fev_q};
          default:         dat_o[7:0] <= 8'h00;
        endcase
      end
      // software writes first, hardware sets below win over clears
      if (wr_lo) begin
        case (adr_i)
          `SP1_ADDR_MASK:  mask_q <= dat_i[7:0];
          `SP1_GIVEN_ADDR: given_q <= dat_i[7:0];
          `SP1_DATA: begin
            txbyte_q <= dat_i[7:0];
            tx_go_q  <= 1'b1;
          end
          `SP1_CTRL: begin
            if (fev_q)
              fe_q <= dat_i[`SP1_CTRL_MSB];
            else
              mode_hi_q <= dat_i[`SP1_CTRL_MSB];
            mode_lo_q <= dat_i[`SP1_CTRL_M1];
            mp_q  <= dat_i[`SP1_CTRL_MP];
            ren_q <= dat_i[`SP1_CTRL_REN];
            // mode 0 receive starts on a rising receiver-on write
            rx_go_q <= dat_i[`SP1_CTRL_REN] && !ren_q &&
                       !(fev_q ? mode_hi_q : dat_i[`SP1_CTRL_MSB]) &&
                       !dat_i[`SP1_CTRL_M1];
            tb8_q <= dat_i[`SP1_CTRL_TB8];
            rb8_q <= dat_i[`SP1_CTRL_RB8];
            ti_q  <= dat_i[`SP1_CTRL_TI];
            ri_q  <= dat_i[`SP1_CTRL_RI];
          end
          `SP1_AUX: begin
            fev_q <= dat_i[`SP1_AUX_FEV];
            dbl_q <= dat_i[`SP1_AUX_DBL];
            ien_q <= dat_i[`SP1_AUX_IEN];
          end
          default: ;
        endcase
      end
      if (sh_tdone)
        ti_q <= 1'b1;
      if (sh_rdone && mode != 2'd0 && !sh_stop)
        fe_q <= 1'b1;
      if (sh_rdone && (mode == 2'd0 || ren_q) && accept) begin
        ri_q    <= 1'b1;
        rxbuf_q <= sh_byte;
        if (mode[1] || !mp_q)
          rb8_q <= sh_nine;
      end
      irq_o <= ien_q && (ti_q || ri_q);
      // mode 0: data on the bidirectional pin, shift clock on txd
      if (mode == 2'd0) begin
        txd_o      <= sh_sclk;
        rxd_o      <= sh_txd;
        rxd_oe_n_o <= sh_oe_n && !(tx_go_q || !sh_txd || !sh_sclk);
      end else begin
        txd_o      <= sh_txd;
        rxd_o      <= 1'b1;
        rxd_oe_n_o <= 1'b1;
      end
    end
  end
endmodule // sp1_port
`default_nettype wire

/* File: hw/sp1_regs.vh */
// constants of the second serial port with address match
// assumes a classic wishbone slave with byte-wide registers in the low data lane
// How it works
// - mode 0 shifts 8 bits synchronously, 12 clocks per bit, 4 with multiprocessor select
// - mode 1 sends 10-bit async frames at the timer 1 rate
// - modes 2 and 3 use 11-bit frames; mode 2 at 64 or 32 clocks
// - modes 2/3 with multiprocessor select need ninth bit 1 to flag receive
// - mode 1 with multiprocessor select drops frames with a bad stop bit
// - with framing view selected, bit 7 is a sticky framing-error flag
// - mode high bit and framing flag are stored apart; view writes keep mode
// - receiver-on enables reception; in mode 0 it starts a synchronous receive
// - modes 2 and 3 transmit the tx ninth bit as the ninth data bit
// - rx ninth bit holds ninth bit in modes 2/3, stop bit in mode 1 without multiprocessor select
// - tx done sets at end of the last data bit; software clears it
// - rx done sets after the stop sample, or after the eighth data bit in mode 0; software clears it
// - masked given-address bits are compared exactly with incoming data
// - unmasked given-address bits are don't care
// - an all-zero mask lets every byte raise receive, though modes 2/3 with multiprocessor select still need ninth bit 1
// - a given-address register holds the individual or broadcast address
// - one data location: write loads tx buffer, read returns rx buffer
// - interrupt request is tx done or rx done, gated by the interrupt enable
`ifndef SP1_REGS_VH
`define SP1_REGS_VH
`define SP1_ADDR_MASK     8'hba
`define SP1_CTRL          8'hc0
`define SP1_DATA          8'hc1
`define SP1_GIVEN_ADDR    8'haa
`define SP1_AUX           8'hc4
`define SP1_RESET_BYTE    8'h00
`define SP1_MODE0_SLOW    16'd12
`define SP1_MODE0_FAST    16'd4
`define SP1_MODE2_SLOW    16'd64
`define SP1_MODE2_FAST    16'd32
`define SP1_T1_PERIOD     16'd87
`define SP1_BITS_MODE0    4'd8
`define SP1_BITS_MODE1    4'd10
`define SP1_BITS_MODE23   4'd11
`define SP1_CTRL_MSB      7
`define SP1_CTRL_M1       6
`define SP1_CTRL_MP       5
`define SP1_CTRL_REN      4
`define SP1_CTRL_TB8      3
`define SP1_CTRL_RB8      2
`define SP1_CTRL_TI       1
`define SP1_CTRL_RI       0
`define SP1_AUX_FEV       0
`define SP1_AUX_DBL       1
`define SP1_AUX_IEN       2
`endif

/* File: hw/sp1_shifter.v */
// one serial engine: tx and rx shifters sharing one bit period, each with its own counter
// assumes rx_i already synchronised; strobes come from the register file
`timescale 1ns/1ns
`default_nettype none
`include "sp1_regs.vh"
module sp1_shifter (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // configuration
  input  wire [1:0]  mode_i,
  input  wire [15:0] period_i,
  input  wire        tx_nine_i,
  // control strobes
  input  wire        tx_go_i,
  input  wire [7:0]  tx_byte_i,
  input  wire        rx_en_i,
  input  wire        rx_go_i,
  // line
  input  wire        rx_i,
  output reg         txd_o,
  output reg         sclk_o,
  output reg         rxd_oe_n_o,
  // completion
  output reg         tx_done_o,
  output reg         rx_done_o,
  output reg  [7:0]  rx_byte_o,
  output reg         rx_nine_o,
  output reg         rx_stop_ok_o
);
  reg [15:0] tcnt_q;
  reg [3:0]  tbit_q;
  reg [10:0] tsh_q;
  reg        tbusy_q;
  reg [15:0] rcnt_q;
  reg [3:0]  rbit_q;
  reg [9:0]  rsh_q;
  reg        rbusy_q;
  reg        rx_prev_q;
  wire [3:0] nbits = (mode_i == 2'd0) ? `SP1_BITS_MODE0 :
                     (mode_i == 2'd1) ? `SP1_BITS_MODE1 : `SP1_BITS_MODE23;
  wire [15:0] half = {1'b0, period_i[15:1]};
  wire tick_t = (tcnt_q == period_i - 16'd1);
  wire tick_r = (rcnt_q == period_i - 16'd1);
  wire mid_r  = (rcnt_q == half);
  // transmit
  always @(posedge clk_i) begin
    tx_done_o <= 1'b0;
    if (rst_i) begin
      tbusy_q <= 1'b0; tcnt_q <= 16'd0; tbit_q <= 4'd0; tsh_q <= 11'h7ff;
      txd_o <= 1'b1; sclk_o <= 1'b1;
    end else if (!tbusy_q) begin
      txd_o <= 1'b1; sclk_o <= 1'b1;
      if (tx_go_i) begin
        tbusy_q <= 1'b1; tcnt_q <= 16'd0; tbit_q <= 4'd0;
        if (mode_i == 2'd0)
          tsh_q <= {3'b111, tx_byte_i};
        else if (mode_i == 2'd1)
          tsh_q <= {2'b11, tx_byte_i, 1'b0};
        else
          tsh_q <= {1'b1, tx_nine_i, tx_byte_i, 1'b0};
      end
    end else begin
      if (mode_i == 2'd0) begin
        txd_o  <= tsh_q[0];
        sclk_o <= (tcnt_q >= half);
      end else
        txd_o <= tsh_q[0];
      tcnt_q <= tick_t ? 16'd0 : tcnt_q + 16'd1;
      if (tick_t) begin
        tsh_q  <= {1'b1, tsh_q[10:1]};
        tbit_q <= tbit_q + 4'd1;
        // last data bit ends one bit before the stop bit
        if (tbit_q == nbits - ((mode_i == 2'd0) ? 4'd1 : 4'd2))
          tx_done_o <= 1'b1;
        if (tbit_q == nbits - 4'd1)
          tbusy_q <= 1'b0;
      end
    end
  end
  // receive
  always @(posedge clk_i) begin
    rx_done_o <= 1'b0;
    if (rst_i) begin
      rbusy_q <= 1'b0; rcnt_q <= 16'd0; rbit_q <= 4'd0; rsh_q <= 10'h000;
      rx_prev_q <= 1'b1; rx_byte_o <= 8'h00; rx_nine_o <= 1'b0;
      rx_stop_ok_o <= 1'b0; rxd_oe_n_o <= 1'b1;
    end else begin
      rx_prev_q <= rx_i;
      if (!rbusy_q) begin
        rcnt_q <= 16'd0; rbit_q <= 4'd0;
        if (mode_i == 2'd0 && rx_go_i) begin
          rbusy_q <= 1'b1;
          rxd_oe_n_o <= 1'b1;
        end else if (mode_i != 2'd0 && rx_en_i && rx_prev_q && !rx_i)
          rbusy_q <= 1'b1;
      end else begin
        rcnt_q <= tick_r ? 16'd0 : rcnt_q + 16'd1;
        if (mid_r) begin
          rsh_q  <= {rx_i, rsh_q[9:1]};
          rbit_q <= rbit_q + 4'd1;
          if (mode_i != 2'd0 && rbit_q == 4'd0 && rx_i)
            rbusy_q <= 1'b0;                 // false start, glitch rejected
          else if (rbit_q == nbits - ((mode_i == 2'd0) ? 4'd1 : 4'd1)) begin
            rbusy_q <= 1'b0;
            rx_done_o <= 1'b1;
            if (mode_i == 2'd0)
              rx_byte_o <= {rx_i, rsh_q[9:3]};
            else if (mode_i == 2'd1) begin
              rx_byte_o <= rsh_q[9:2];
              rx_nine_o <= rx_i;
            end else begin
              rx_byte_o <= rsh_q[8:1];
              rx_nine_o <= rsh_q[9];
            end
            rx_stop_ok_o <= (mode_i == 2'd0) | rx_i;
          end
        end
      end
    end
  end
endmodule // sp1_shifter
`default_nettype wire

/* File: tb/sp1_port_asserts.sv */
// checker for the serial port's bus handshake, readback and reset outputs
// assumes it is bound to sp1_port and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module sp1_port_chk #(
  parameter [15:0] T1_PERIOD = 16'd87
) (
  // system
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // line and interrupt
  input wire logic        rxd_i,
  input wire logic        rxd_o,
  input wire logic        rxd_oe_n_o,
  input wire logic        txd_o,
  input wire logic        irq_o
);
  logic [7:0] mask_q;
  wire        taken = cyc_i && stb_i && !ack_o;
  wire        mapped = adr_i == 8'hba || adr_i == 8'hc0 || adr_i == 8'hc1 ||
                       adr_i == 8'haa || adr_i == 8'hc4;
  // shadow of the mask register, so reads can be judged without peeking inside
  always_ff @(posedge clk_i) begin
    if (rst_i)
      mask_q <= 8'h00;
    else if (taken && we_i && sel_i[0] && adr_i == 8'hba)
      mask_q <= dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_on_take: assert property (taken |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without a request");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_unmapped_zero: assert property (ack_o && !$past(we_i) && !$past(mapped) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_mask_readback: assert property (
    ack_o && !$past(we_i) && $past(adr_i) == 8'hba |-> dat_o[7:0] == mask_q)
    else $error("mask readback wrong");
  a_irq_fall_write: assert property (
    $fell(irq_o) |-> $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2))
    else $error("irq dropped without a write");
  a_reset_outputs: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> txd_o && rxd_o && rxd_oe_n_o && !irq_o && !ack_o)
    else $error("outputs not idle after reset");
endmodule // sp1_port_chk
bind sp1_port sp1_port_chk #(.T1_PERIOD(T1_PERIOD)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_n_o(rxd_oe_n_o),
  .txd_o(txd_o), .irq_o(irq_o));
`default_nettype wire

/* File: tb/sp1_node.sv */
// remote serial node: sends frames bit by bit and captures frames off the line
// assumes the line idles high and one bit lasts per clocks
`timescale 1ns/1ns
`default_nettype none
module sp1_node (
  // clock
  input  wire logic clk_i,
  // line
  input  wire logic txd_i,
  output var  logic rxd_o
);
  initial rxd_o = 1'b1;
  // bits go out lsb first; caller sets the ninth bit per byte kind
  task automatic send(input int per, input int n, input logic [10:0] bits);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rxd_o <= bits[i];
      repeat (per - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  // mid-bit sampling; a missing start bit leaves garbage for the caller to flag
  task automatic grab(input int per, input int n, output logic [10:0] bits);
    int k;
    bits = '0;
    for (k = 0; k < 4000 && txd_i !== 1'b0; k++) @(posedge clk_i);
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      repeat (per) @(posedge clk_i);
    end
  endtask
endmodule // sp1_node
`default_nettype wire

/* File: tb/sp1_port_tb_top.sv */
// self-checking bench for the serial port: registers, transmit, receive, framing
// assumes sp1_port with a shortened timer rate and the node model on the line
`timescale 1ns/1ns
`default_nettype none
`define TB_CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module sp1_port_tb_top;
  localparam int T1 = 8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  wire  [31:0] dat_o;
  wire         ack_o, node_tx, rxd_o, oe_n, txd_o, irq_o;
  wire         rxd_pin = oe_n ? node_tx : rxd_o;
  logic [7:0]  q;
  logic [10:0] b;
  int          num_errors = 0;
  int          checks = 0;
  sp1_port #(.T1_PERIOD(16'd8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_n_o(oe_n), .txd_o(txd_o),
    .irq_o(irq_o));
  sp1_node i_node (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(node_tx));
  initial forever #50 clk_i = ~clk_i;
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    q = dat_o[7:0];
    if (n == 20) `TB_CHK(1'b0, 1'b1)
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    `TB_CHK(q, e)
  endtask
  task automatic t_regs;
    rd(8'hba, 8'h00);
    rd(8'hc0, 8'h00);
    rd(8'haa, 8'h00);
    wb(8'h10, 1'b1, 8'hff);
    rd(8'h10, 8'h00);
    wb(8'haa, 1'b1, 8'h5a);
    rd(8'haa, 8'h5a);
    $display("test regs finished");
  endtask
  task automatic t_tx;
    wb(8'hc4, 1'b1, 8'h04);
    wb(8'hc0, 1'b1, 8'h40);
    fork wb(8'hc1, 1'b1, 8'ha5); i_node.grab(T1, 10, b); join
    `TB_CHK(b[9:0], {1'b1, 8'ha5, 1'b0})
    rd(8'hc0, 8'h42);
    `TB_CHK(irq_o, 1'b1)
    wb(8'hc0, 1'b1, 8'hc8);
    repeat (2) @(posedge clk_i);
    `TB_CHK(irq_o, 1'b0)
    fork wb(8'hc1, 1'b1, 8'h3c); i_node.grab(T1, 11, b); join
    `TB_CHK(b, {2'b11, 8'h3c, 1'b0})
    $display("test tx finished");
  endtask
  task automatic t_rx;
    wb(8'hc4, 1'b1, 8'h06);
    wb(8'hba, 1'b1, 8'h0f);
    wb(8'hc0, 1'b1, 8'hb0);
    i_node.send(32, 11, {2'b11, 8'h3a, 1'b0});
    rd(8'hc0, 8'hb5);
    rd(8'hc1, 8'h3a);
    `TB_CHK(irq_o, 1'b1)
    wb(8'hc0, 1'b1, 8'hb0);
    i_node.send(32, 11, {2'b11, 8'h3b, 1'b0});
    wb(8'hc0, 1'b0, 8'h00);
    `TB_CHK(q[0], 1'b0)
    i_node.send(32, 11, {2'b10, 8'h3a, 1'b0});
    wb(8'hc0, 1'b0, 8'h00);
    `TB_CHK(q[0], 1'b0)
    wb(8'hba, 1'b1, 8'h00);
    i_node.send(32, 11, {2'b11, 8'hc7, 1'b0});
    wb(8'hc0, 1'b0, 8'h00);
    `TB_CHK(q[0], 1'b1)
    $display("test rx finished");
  endtask
  task automatic t_fe;
    // mode bits must be set before the framing view hides bit 7
    wb(8'hc4, 1'b1, 8'h04);
    wb(8'hc0, 1'b1, 8'h70);
    wb(8'hc4, 1'b1, 8'h05);
    i_node.send(T1, 10, {2'b00, 8'ha5, 1'b0});
    wb(8'hc0, 1'b0, 8'h00);
    `TB_CHK(q & 8'h81, 8'h80)
    wb(8'hc0, 1'b1, 8'hd0);
    i_node.send(T1, 10, {2'b01, 8'h81, 1'b0});
    rd(8'hc1, 8'h81);
    wb(8'hc4, 1'b1, 8'h04);
    rd(8'hc0, 8'h55);
    $display("test framing finished");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_fe;
    report_and_stop;
  end
  // frames above take under two thousand cycles; well past that means a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    report_and_stop;
  end
endmodule // sp1_port_tb_top
`default_nettype wire
